//--- verilog/dso_status_out.sv
// Drive status output logic: brake, analog loss, second-stage boost and link timeout
//
// Overview of operation
// - Brake release output high only while commanding the external brake open.
// - Brake release output low whenever the motor is not being driven.
// - Brake error high when brake control is on, the brake is commanded open and output current is below the releasing current.
// - Brake error low when brake control is off or current is adequate.
// - Each of three analog inputs raises its own loss flag below its threshold.
// - Thresholds take 0 to 100 percent; setting 255 disables that input's detection.
// - While an input is lost, the threshold value replaces the measured value.
// - Analog loss requests a decelerate-to-stop in addition to the loss flag.
// - While running, boost output turns on when process variable is below lower limit.
// - Boost output turns off once process variable rises above upper limit.
// - Both limits are in percent, same units as the setpoint.
// - Removing the run command forces the boost output off.
// - Boost output is only a stage switch, never a process alarm.
// - Link-timeout output rises when the master is silent longer than the limit.
// - Link-timeout output stays high until valid binary-framed traffic returns or binary framing is switched off.
// - Link monitoring applies to the binary framing only, not the text variant.
// - A selectable action is carried out when the link times out.
`timescale 1ns/1ps
module dso_status_out
	import dso_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES,
	parameter int NT          = N_TERM
) (
	// Clock and reset
	input  wire logic                      clk_in,
	input  wire logic                      resetn_in,
	// Drive state
	input  wire logic                      forward_run_cmd_in,
	input  wire logic                      motor_driving_in,
	// Brake control
	input  wire logic                      brake_enable_in,
	input  wire logic                      brake_open_req_in,
	input  wire logic [CUR_W-1:0]          output_current_in,
	input  wire logic [CUR_W-1:0]          brake_release_current_in,
	// Analog references, percent
	input  wire logic [PCT_W-1:0]          volt_ref_input_in,
	input  wire logic [PCT_W-1:0]          current_ref_input_in,
	input  wire logic [PCT_W-1:0]          aux_ref_input_in,
	input  wire logic [PCT_W-1:0]          volt_loss_threshold_in,
	input  wire logic [PCT_W-1:0]          current_loss_threshold_in,
	input  wire logic [PCT_W-1:0]          aux_loss_threshold_in,
	// Process variable and boost limits, percent
	input  wire logic [PCT_W-1:0]          pv_in,
	input  wire logic [PCT_W-1:0]          pv_upper_limit_in,
	input  wire logic [PCT_W-1:0]          pv_lower_limit_in,
	// Serial link monitor
	input  wire logic                      rtu_mode_in,
	input  wire logic                      frame_valid_in,
	input  wire logic [TMO_W-1:0]          comm_timeout_limit_in,
	input  wire logic [2:0]                comm_error_action_in,
	// Terminal routing
	input  wire logic [NT-1:0][CODE_W-1:0] term_sel_in,
	input  wire logic [NT-1:0]             term_other_in,
	// Status outputs
	output logic                           brake_release_out,
	output logic                           brake_fault_out,
	output logic                           volt_input_loss_flag_out,
	output logic                           current_input_loss_flag_out,
	output logic                           aux_input_loss_flag_out,
	output logic                           second_stage_boost_out,
	output logic                           link_timeout_out,
	// Substituted references
	output logic [PCT_W-1:0]               volt_ref_used_out,
	output logic [PCT_W-1:0]               current_ref_used_out,
	output logic [PCT_W-1:0]               aux_ref_used_out,
	// Stop and trip requests
	output logic                           decel_stop_req_out,
	output logic                           comm_trip_out,
	output logic                           coast_stop_req_out,
	// Terminals
	output logic [NT-1:0]                  term_out
);

	localparam int MSC_W = $clog2(MS_CYCLES_P + 1);
	localparam logic [MSC_W-1:0] MS_LAST = MSC_W'(MS_CYCLES_P - 1);

	// Pick the routed status bit, or pass the terminal's other source through
	function automatic logic route_term(input logic [CODE_W-1:0] code, input dso_status_t st,
		input logic other);
		logic r;
		r = other;
		unique case (code)
			OPT_BRAKE_REL: r = st.brake_release;
			OPT_BRAKE_ERR: r = st.brake_fault;
			OPT_VOLT_LOSS: r = st.volt_loss;
			OPT_CURR_LOSS: r = st.current_loss;
			OPT_AUX_LOSS:  r = st.aux_loss;
			OPT_BOOST:     r = st.boost;
			OPT_LINK_TMO:  r = st.link_timeout;
			default:       r = other;
		endcase
		return r;
	endfunction : route_term

	// Reset release through two flops
	logic rst_meta_r;
	logic rst_sync_r;
	logic rstn;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rstn = rst_sync_r;

	// Run command pin: three flops, accepted once stages two and three agree
	logic [2:0] run_sync_r;
	logic [2:0] run_sync_nxt;
	logic       run_r;
	logic       run_nxt;

	always_comb begin
		run_sync_nxt = {run_sync_r[1:0], forward_run_cmd_in};
		run_nxt      = (run_sync_r[1] == run_sync_r[2]) ? run_sync_r[2] : run_r;
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			run_sync_r <= 3'h0;
			run_r      <= 1'b0;
		end else begin
			run_sync_r <= run_sync_nxt;
			run_r      <= run_nxt;
		end
	end

	// Analog channels
	dso_ain_t     ain [3];
	dso_ain_res_t ares [3];

	assign ain[0] = '{value: volt_ref_input_in,    threshold: volt_loss_threshold_in};
	assign ain[1] = '{value: current_ref_input_in, threshold: current_loss_threshold_in};
	assign ain[2] = '{value: aux_ref_input_in,     threshold: aux_loss_threshold_in};

	for (genvar g = 0; g < 3; g++) begin : g_ain
		dso_ain_check u_chk (
			.ain_in  (ain[g]),
			.res_out (ares[g])
		);
	end

	// Boost stage with hysteresis between the two limits; a stage switch only, no alarm latch
	dso_boost_st_t boost_st_r;
	dso_boost_st_t boost_st_nxt;

	always_comb begin
		boost_st_nxt = boost_st_r;
		unique case (boost_st_r)
			BOOST_IDLE: begin
				if (run_r && (pv_in < pv_lower_limit_in)) begin
					boost_st_nxt = BOOST_ON;
				end
			end
			BOOST_ON: begin
				if (!run_r) begin
					boost_st_nxt = BOOST_IDLE;
				end else if (pv_in > pv_upper_limit_in) begin
					boost_st_nxt = BOOST_IDLE;
				end
			end
			default: boost_st_nxt = BOOST_IDLE;
		endcase
		// Otherwise state holds between the limits
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			boost_st_r <= BOOST_IDLE;
		end else begin
			boost_st_r <= boost_st_nxt;
		end
	end

	// Link watchdog: millisecond prescaler and silence counter
	dso_link_st_t     link_st_r;
	dso_link_st_t     link_st_nxt;
	logic [MSC_W-1:0] ms_div_r;
	logic [MSC_W-1:0] ms_div_nxt;
	logic [TMO_W-1:0] ms_cnt_r;
	logic [TMO_W-1:0] ms_cnt_nxt;
	logic             frame_ok;
	logic             tmo_set;

	// Text framing never feeds the watchdog
	assign frame_ok = rtu_mode_in && frame_valid_in;
	// Strictly longer than the limit; a frame this cycle proves the master is alive
	assign tmo_set  = rtu_mode_in && (comm_timeout_limit_in != TMO_OFF) && !frame_ok
		&& (ms_cnt_r > comm_timeout_limit_in);

	always_comb begin
		ms_div_nxt  = ms_div_r;
		ms_cnt_nxt  = ms_cnt_r;
		link_st_nxt = link_st_r;
		if (!rtu_mode_in || frame_ok) begin
			ms_div_nxt = '0;
			ms_cnt_nxt = '0;
		end else if (ms_div_r == MS_LAST) begin
			ms_div_nxt = '0;
			if (ms_cnt_r != '1) begin
				ms_cnt_nxt = ms_cnt_r + TMO_W'(1);
			end
		end else begin
			ms_div_nxt = ms_div_r + MSC_W'(1);
		end
		unique case (link_st_r)
			LINK_OK: begin
				if (tmo_set) begin
					link_st_nxt = LINK_LOST;
				end
			end
			LINK_LOST: begin
				// Stale count would hold the flag forever, so a frame masks it
				if (!tmo_set && (frame_ok || !rtu_mode_in)) begin
					link_st_nxt = LINK_OK;
				end
			end
			default: link_st_nxt = LINK_OK;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			link_st_r <= LINK_OK;
			ms_div_r  <= '0;
			ms_cnt_r  <= '0;
		end else begin
			link_st_r <= link_st_nxt;
			ms_div_r  <= ms_div_nxt;
			ms_cnt_r  <= ms_cnt_nxt;
		end
	end

	// Status conditions
	dso_status_t st;
	logic        lost;
	logic        act_trip;
	logic        act_decel;
	logic        act_coast;

	always_comb begin
		st               = STATUS_RST;
		// Brake opens only while driving and the sequencer asks; a dead drive keeps it shut
		st.brake_release = brake_enable_in && motor_driving_in && brake_open_req_in;
		st.brake_fault   = brake_enable_in && brake_open_req_in
			&& (output_current_in < brake_release_current_in);
		st.volt_loss     = ares[0].loss;
		st.current_loss  = ares[1].loss;
		st.aux_loss      = ares[2].loss;
		st.boost         = (boost_st_r == BOOST_ON);
		st.link_timeout  = (link_st_r == LINK_LOST);
	end

	// Timeout action decode
	always_comb begin
		lost      = st.link_timeout;
		act_trip  = 1'b0;
		act_decel = 1'b0;
		act_coast = 1'b0;
		unique case (comm_error_action_in)
			ACT_TRIP:       act_trip  = lost;
			ACT_DECEL_TRIP: begin
				act_decel = lost;
				act_trip  = lost;
			end
			ACT_COAST:      act_coast = lost;
			ACT_DECEL_STOP: act_decel = lost;
			default:        act_trip  = 1'b0;
		endcase
	end

	// Output registers: every port comes from a flop
	logic [PCT_W-1:0] used_nxt [3];
	logic [NT-1:0]    term_nxt;
	logic             decel_nxt;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			used_nxt[i] = ares[i].used;
		end
		for (int i = 0; i < NT; i++) begin
			term_nxt[i] = route_term(term_sel_in[i], st, term_other_in[i]);
		end
		decel_nxt = ares[0].loss || ares[1].loss || ares[2].loss || act_decel;
	end

	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			brake_release_out           <= 1'b0;
			brake_fault_out             <= 1'b0;
			volt_input_loss_flag_out    <= 1'b0;
			current_input_loss_flag_out <= 1'b0;
			aux_input_loss_flag_out     <= 1'b0;
			second_stage_boost_out      <= 1'b0;
			link_timeout_out            <= 1'b0;
			volt_ref_used_out           <= '0;
			current_ref_used_out        <= '0;
			aux_ref_used_out            <= '0;
			decel_stop_req_out          <= 1'b0;
			comm_trip_out               <= 1'b0;
			coast_stop_req_out          <= 1'b0;
			term_out                    <= '0;
		end else begin
			brake_release_out           <= st.brake_release;
			brake_fault_out             <= st.brake_fault;
			volt_input_loss_flag_out    <= st.volt_loss;
			current_input_loss_flag_out <= st.current_loss;
			aux_input_loss_flag_out     <= st.aux_loss;
			second_stage_boost_out      <= st.boost;
			link_timeout_out            <= st.link_timeout;
			volt_ref_used_out           <= used_nxt[0];
			current_ref_used_out        <= used_nxt[1];
			aux_ref_used_out            <= used_nxt[2];
			decel_stop_req_out          <= decel_nxt;
			comm_trip_out               <= act_trip;
			coast_stop_req_out          <= act_coast;
			term_out                    <= term_nxt;
		end
	end

endmodule : dso_status_out

//--- verilog/dso_pkg.sv
// Package of constants, codes and carrier types for the drive status output logic
package dso_pkg;

	// Percent-scaled analog, limit and setpoint values
	localparam int              PCT_W         = 8;
	localparam logic [7:0]      LOSS_DISABLE  = 8'hff;   // Threshold setting that turns loss detection off
	localparam int              CUR_W         = 16;      // Output and releasing current width
	localparam int              TMO_W         = 16;      // Timeout limit in milliseconds
	localparam logic [15:0]     TMO_OFF       = 16'h0000; // Limit value that disables link monitoring

	// Programmable output terminals and option codes
	localparam int              CODE_W        = 6;
	localparam int              N_TERM        = 6;       // Five intelligent outputs plus the relay
	localparam logic [5:0]      OPT_BRAKE_REL = 6'h13;   // 19
	localparam logic [5:0]      OPT_BRAKE_ERR = 6'h14;   // 20
	localparam logic [5:0]      OPT_VOLT_LOSS = 6'h1b;   // 27
	localparam logic [5:0]      OPT_CURR_LOSS = 6'h1c;   // 28
	localparam logic [5:0]      OPT_AUX_LOSS  = 6'h1d;   // 29
	localparam logic [5:0]      OPT_BOOST     = 6'h1f;   // 31
	localparam logic [5:0]      OPT_LINK_TMO  = 6'h20;   // 32

	// Timing
	localparam int              CLK_PERIOD_NS = 4;
	localparam int              MS_NS         = 1000000;
	localparam int              MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	// Action on link timeout
	typedef enum logic [2:0] {
		ACT_TRIP       = 3'h0,
		ACT_DECEL_TRIP = 3'h1,
		ACT_IGNORE     = 3'h2,
		ACT_COAST      = 3'h3,
		ACT_DECEL_STOP = 3'h4
	} dso_comm_act_t;

	// Boost stage states
	typedef enum logic [1:0] {
		BOOST_IDLE = 2'b01,
		BOOST_ON   = 2'b10
	} dso_boost_st_t;

	// Link watchdog states
	typedef enum logic [1:0] {
		LINK_OK   = 2'b01,
		LINK_LOST = 2'b10
	} dso_link_st_t;

	// One analog channel: measured value and its loss threshold
	typedef struct packed {
		logic [7:0] value;
		logic [7:0] threshold;
	} dso_ain_t;

	// Result for one analog channel
	typedef struct packed {
		logic       loss;
		logic [7:0] used;
	} dso_ain_res_t;

	// Status conditions that may be routed to terminals
	typedef struct packed {
		logic brake_release;
		logic brake_fault;
		logic volt_loss;
		logic current_loss;
		logic aux_loss;
		logic boost;
		logic link_timeout;
	} dso_status_t;

	localparam dso_status_t STATUS_RST = 7'h00;

endpackage : dso_pkg

//--- verilog/dso_ain_check.sv
// Loss detection and threshold substitution for one analog reference input
`timescale 1ns/1ps
module dso_ain_check
	import dso_pkg::*;
(
	// Channel in
	input  wire dso_ain_t     ain_in,
	// Result out
	output dso_ain_res_t      res_out
);

	logic enabled;

	// Threshold of 255 switches the check off; values reach at most 100 percent
	assign enabled      = (ain_in.threshold != LOSS_DISABLE);
	assign res_out.loss = enabled && (ain_in.value < ain_in.threshold);
	// Lost input is replaced by the threshold so the reference never sags further
	assign res_out.used = res_out.loss ? ain_in.threshold : ain_in.value;

endmodule : dso_ain_check

//--- dv/dso_master_model.sv
// Serial bus master model sending valid frames at a chosen spacing
`timescale 1ns/1ps
module dso_master_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// Polling control
	input  wire logic       poll_en_in,
	input  wire logic [7:0] gap_in,
	// Frame strobe toward the block
	output logic            frame_valid_out
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic       fv_nxt;
	// One pulse per gap; polling off means silence, so the watchdog runs out
	always_comb begin
		cnt_nxt = cnt_r + 8'h01;
		fv_nxt  = 1'b0;
		if (!poll_en_in) begin
			cnt_nxt = 8'h00;
		end else if (cnt_r >= gap_in) begin
			cnt_nxt = 8'h00;
			fv_nxt  = 1'b1;
		end
	end
	// Counter and strobe registers
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r           <= 8'h00;
			frame_valid_out <= 1'b0;
		end else begin
			cnt_r           <= cnt_nxt;
			frame_valid_out <= fv_nxt;
		end
	end
endmodule : dso_master_model

//--- dv/dso_status_monitor.sv
// Checker for the drive status output logic
`timescale 1ns/1ps
module dso_status_monitor
	import dso_pkg::*;
#(
	parameter int NT = N_TERM
) (
	// Clock, reset and controls
	input wire logic                      clk_in, resetn_in, forward_run_cmd_in,
	input wire logic                      motor_driving_in, brake_enable_in, brake_open_req_in,
	input wire logic                      rtu_mode_in, frame_valid_in,
	input wire logic [CUR_W-1:0]          output_current_in, brake_release_current_in,
	input wire logic [PCT_W-1:0]          current_ref_input_in, current_loss_threshold_in,
	input wire logic [PCT_W-1:0]          pv_in, pv_upper_limit_in, pv_lower_limit_in,
	input wire logic [NT-1:0][CODE_W-1:0] term_sel_in,
	input wire logic [NT-1:0]             term_other_in,
	// Observed outputs
	input wire logic                      brake_release_out, brake_fault_out, decel_stop_req_out,
	input wire logic                      current_input_loss_flag_out, second_stage_boost_out,
	input wire logic                      link_timeout_out,
	input wire logic [PCT_W-1:0]          current_ref_used_out,
	input wire logic [NT-1:0]             term_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	logic             cur_lost;
	logic             pv_low;
	logic [PCT_W-1:0] cur_used;
	// Expected conditions; 255 threshold means detection off
	assign cur_lost = current_loss_threshold_in != LOSS_DISABLE && current_ref_input_in < current_loss_threshold_in;
	assign cur_used = cur_lost ? current_loss_threshold_in : current_ref_input_in;
	assign pv_low   = pv_in < pv_lower_limit_in;
	sequence s_above;
		(pv_in > pv_upper_limit_in) [*3];
	endsequence
	sequence s_stopped;
		(!forward_run_cmd_in) [*8];
	endsequence
	a_brake_rel_cmd: assert property (
		brake_release_out == $past(brake_enable_in && motor_driving_in && brake_open_req_in))
		else $error("brake release wrong");
	a_brake_fault_low: assert property (
		brake_fault_out == $past(brake_enable_in && brake_open_req_in
		&& output_current_in < brake_release_current_in)) else $error("brake fault wrong");
	a_cur_loss_flag: assert property (
		current_input_loss_flag_out == $past(cur_lost)) else $error("loss flag wrong");
	a_cur_ref_subst: assert property (
		current_ref_used_out == $past(cur_used)) else $error("substituted value wrong");
	a_loss_decel_req: assert property (
		current_input_loss_flag_out |-> decel_stop_req_out) else $error("no stop on loss");
	a_boost_rise_low: assert property (
		$rose(second_stage_boost_out) |-> $past(pv_low, 2)) else $error("boost rose too early");
	a_boost_off_high: assert property (
		s_above |-> !second_stage_boost_out) else $error("boost on above upper limit");
	a_boost_off_stop: assert property (
		s_stopped |-> !second_stage_boost_out) else $error("boost on while stopped");
	a_link_clear_frame: assert property (
		link_timeout_out && frame_valid_in && rtu_mode_in |-> ##[1:3] !link_timeout_out)
		else $error("timeout not cleared");
	a_link_text_off: assert property (
		(!rtu_mode_in) [*3] |-> !link_timeout_out) else $error("timeout in text mode");
	a_term_route_rel: assert property (
		$past(term_sel_in[0]) == OPT_BRAKE_REL |->
		term_out[0] == $past(brake_enable_in && motor_driving_in && brake_open_req_in))
		else $error("terminal routing wrong");
	a_term_route_other: assert property (
		$past(term_sel_in[0]) == 6'h3f |-> term_out[0] == $past(term_other_in[0]))
		else $error("unused code disturbs terminal");
endmodule : dso_status_monitor

bind dso_status_out dso_status_monitor #(.NT(NT)) i_mon (.*);

//--- dv/testbench.sv
// Self-checking bench for the drive status output logic
`timescale 1ns/1ps
module testbench;
	import dso_pkg::*;
	logic                          clk_in, resetn_in, forward_run_cmd_in, motor_driving_in;
	logic                          brake_enable_in, brake_open_req_in, rtu_mode_in, frame_valid_in;
	logic                          poll_en;
	logic [CUR_W-1:0]              output_current_in, brake_release_current_in;
	logic [PCT_W-1:0]              volt_ref_input_in, current_ref_input_in, aux_ref_input_in, gap;
	logic [PCT_W-1:0]              volt_loss_threshold_in, current_loss_threshold_in, aux_loss_threshold_in;
	logic [PCT_W-1:0]              pv_in, pv_upper_limit_in, pv_lower_limit_in, volt_ref_used_out;
	logic [PCT_W-1:0]              current_ref_used_out, aux_ref_used_out;
	logic [TMO_W-1:0]              comm_timeout_limit_in;
	logic [2:0]                    comm_error_action_in;
	logic [N_TERM-1:0][CODE_W-1:0] term_sel_in;
	logic [N_TERM-1:0]             term_other_in, term_out;
	logic                          brake_release_out, brake_fault_out, volt_input_loss_flag_out;
	logic                          current_input_loss_flag_out, aux_input_loss_flag_out;
	logic                          second_stage_boost_out, link_timeout_out, decel_stop_req_out;
	logic                          comm_trip_out, coast_stop_req_out;
	int                            miscompares, check_count;
	// Short millisecond so the watchdog trips in a few cycles
	dso_status_out #(.MS_CYCLES_P(4)) i_dut (.*);
	dso_master_model i_master (.clk_in(clk_in), .resetn_in(resetn_in), .poll_en_in(poll_en),
		.gap_in(gap), .frame_valid_out(frame_valid_in));
	// 250 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	// Bounded wait on the link flag; running out counts as a mismatch
	task automatic wait_link(input logic lvl);
		int n;
		n = 0;
		while (link_timeout_out !== lvl && n < 40) begin
			tick(1);
			n++;
		end
		chk(link_timeout_out, lvl);
		if (link_timeout_out !== lvl) results();
	endtask : wait_link
	// All enable, drive, request and low-current combinations
	task automatic t_brake;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_in);
			{brake_enable_in, motor_driving_in, brake_open_req_in} <= i[2:0];
			output_current_in <= i[3] ? 16'h0010 : 16'h0020;
			tick(1);
			chk(brake_release_out, &i[2:0]);
			chk(brake_fault_out, i[2] & i[0] & i[3]);
		end
	endtask : t_brake
	// Below, at and disabled threshold on each channel in turn
	task automatic t_loss;
		logic [2:0][7:0] v, th, e;
		for (int k = 0; k < 9; k++) begin
			v  = {3{8'h64}};
			th = {3{8'h32}};
			v[k%3] = (k < 3) ? 8'h31 : (k < 6) ? 8'h32 : 8'h00;
			if (k >= 6) th[k%3] = LOSS_DISABLE;
			e = v;
			if (k < 3) e[k] = 8'h32;
			@(posedge clk_in);
			{volt_ref_input_in, current_ref_input_in, aux_ref_input_in} <= {v[0], v[1], v[2]};
			{volt_loss_threshold_in, current_loss_threshold_in, aux_loss_threshold_in} <= {th[0], th[1], th[2]};
			tick(1);
			chk({volt_input_loss_flag_out, current_input_loss_flag_out, aux_input_loss_flag_out},
				(k < 3) ? 3'b100 >> k : 3'b000);
			chk({volt_ref_used_out, current_ref_used_out, aux_ref_used_out}, {e[0], e[1], e[2]});
			chk(decel_stop_req_out, k < 3);
		end
	endtask : t_loss
	// Run and process variable walk through both limits and a stop
	task automatic t_boost;
		logic [8:0] st [9] = '{9'h014, 9'h114, 9'h132, 9'h13c, 9'h13d, 9'h132, 9'h127, 9'h132, 9'h014};
		logic [8:0] ex = 9'b011001110;
		for (int j = 0; j < 9; j++) begin
			@(posedge clk_in);
			{forward_run_cmd_in, pv_in} <= st[j];
			tick(12);
			chk(second_stage_boost_out, ex[j]);
			chk(term_out[3], ex[j]);
		end
	endtask : t_boost
	// Silence per action code, then resumed polling, then text framing
	task automatic t_link;
		logic [2:0] a;
		@(posedge clk_in);
		rtu_mode_in <= 1'b1;
		poll_en     <= 1'b1;
		tick(40);
		chk(link_timeout_out, 1'b0);
		for (int i = 0; i < 6; i++) begin
			a = i[2:0];
			@(posedge clk_in);
			comm_error_action_in <= a;
			poll_en              <= 1'b0;
			tick(6);
			chk(link_timeout_out, 1'b0);
			wait_link(1'b1);
			tick(2);
			chk({comm_trip_out, decel_stop_req_out, coast_stop_req_out}, {a < 2, a == 1 || a == 4, a == 3});
			@(posedge clk_in);
			poll_en <= 1'b1;
			wait_link(1'b0);
			tick(2);
			chk({comm_trip_out, decel_stop_req_out, coast_stop_req_out}, 3'b000);
		end
		@(posedge clk_in);
		rtu_mode_in <= 1'b0;
		poll_en     <= 1'b0;
		tick(40);
		chk(link_timeout_out, 1'b0);
	endtask : t_link
	// Every option code on all terminals with a known status set
	task automatic t_route;
		logic [5:0] cd [8] = '{OPT_BRAKE_REL, OPT_BRAKE_ERR, OPT_VOLT_LOSS, OPT_CURR_LOSS,
			OPT_AUX_LOSS, OPT_BOOST, OPT_LINK_TMO, 6'h3f};
		logic [7:0] ex = 8'h41;
		@(posedge clk_in);
		{brake_enable_in, motor_driving_in, brake_open_req_in} <= 3'b111;
		output_current_in <= 16'h0020;
		rtu_mode_in       <= 1'b1;
		term_other_in     <= 6'h2a;
		wait_link(1'b1);
		for (int j = 0; j < 8; j++) begin
			@(posedge clk_in);
			term_sel_in <= {N_TERM{cd[j]}};
			tick(1);
			chk(term_out, (j == 7) ? 6'h2a : {N_TERM{ex[j]}});
		end
	endtask : t_route
	// Idle values, reset, then the scenarios
	initial begin
		{resetn_in, forward_run_cmd_in, motor_driving_in, brake_enable_in, brake_open_req_in} = '0;
		{rtu_mode_in, poll_en, comm_error_action_in, pv_in, term_other_in} = '0;
		{volt_ref_input_in, current_ref_input_in, aux_ref_input_in} = '0;
		{volt_loss_threshold_in, current_loss_threshold_in, aux_loss_threshold_in} = '0;
		output_current_in        = 16'h0020;
		brake_release_current_in = 16'h0020;
		pv_lower_limit_in        = 8'h28;
		pv_upper_limit_in        = 8'h3c;
		comm_timeout_limit_in    = 16'h0001;
		gap                      = 8'h03;
		term_sel_in              = '0;
		term_sel_in[0]           = OPT_BRAKE_REL;
		term_sel_in[3]           = OPT_BOOST;
		miscompares              = 0;
		check_count              = 0;
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		tick(3);
		t_brake();
		t_loss();
		t_boost();
		t_link();
		t_route();
		results();
	end
endmodule : testbench
